// file: dtm_pkg.sv
// constants for the two-channel eight-bit timer
package dtm_pkg;
   // register byte offsets on the AXI4-Lite port
   localparam logic [4:0] OFF_COUNT   = 5'h00;
   localparam logic [4:0] OFF_MATCH_A = 5'h04;
   localparam logic [4:0] OFF_MATCH_B = 5'h08;
   localparam logic [4:0] OFF_CTRL0   = 5'h0c;
   localparam logic [4:0] OFF_CTRL1   = 5'h10;
   localparam logic [4:0] OFF_FLAG0   = 5'h14;
   localparam logic [4:0] OFF_FLAG1   = 5'h18;
   // reset values and the counter maximum
   localparam logic [7:0] COUNT_RST   = 8'h00;
   localparam logic [7:0] MATCH_RST   = 8'hff;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [4:0] FCTL_RST    = 5'h00;
   localparam logic [7:0] COUNT_MAX   = 8'hff;
   // timer_control_reg fields
   localparam int CTL_IEB = 7;
   localparam int CTL_IEA = 6;
   localparam int CTL_IEW = 5;
   localparam int CTL_CLR = 3;
   localparam int CTL_CKS = 0;
   // timer_flag_control_reg fields
   localparam int FCR_FLG = 5;
   localparam int FCR_ADC = 4;
   localparam int FCR_OSB = 2;
   localparam int FCR_OSA = 0;
   // flag index inside the three-bit flag group
   localparam int FLG_W = 0;
   localparam int FLG_A = 1;
   localparam int FLG_B = 2;
   // count clock select codes
   localparam logic [2:0] CKS_STOP  = 3'h0;
   localparam logic [2:0] CKS_DIV8  = 3'h1;
   localparam logic [2:0] CKS_DIV64 = 3'h2;
   localparam logic [2:0] CKS_DIV8K = 3'h3;
   localparam logic [2:0] CKS_CASC  = 3'h4;
   localparam logic [2:0] CKS_EXTR  = 3'h5;
   localparam logic [2:0] CKS_EXTF  = 3'h6;
   localparam logic [2:0] CKS_EXTB  = 3'h7;
   // clear select codes
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A    = 2'h1;
   localparam logic [1:0] CLR_B    = 2'h2;
   localparam logic [1:0] CLR_EXT  = 2'h3;
   // output select codes
   localparam logic [1:0] OS_KEEP = 2'h0;
   localparam logic [1:0] OS_LOW  = 2'h1;
   localparam logic [1:0] OS_HIGH = 2'h2;
   localparam logic [1:0] OS_TOG  = 2'h3;
   // prescaler
   localparam int          PRESC_W    = 13;
   localparam int          DIV8       = 8;
   localparam int          DIV64      = 64;
   localparam int          DIV8K      = 8192;
   localparam logic [12:0] MASK_DIV8  = 13'(DIV8 - 1);
   localparam logic [12:0] MASK_DIV64 = 13'(DIV64 - 1);
   localparam logic [12:0] MASK_DIV8K = 13'(DIV8K - 1);
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dtm_pkg

// file: dtm_timer.sv
// two-channel eight-bit timer with AXI4-Lite register port
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - each channel has an eight-bit counter stepping up once per selected clock edge
// - counters reset to zero
// - wrap from all ones to zero sets the channel wrap flag
// - count clock is clock/8, /64, /8192 or the external clock pin
// - counter clears on match A, match B or external clear pin, as selected
// - match A constant is compared with the counter, equality sets match A flag
// - match A compare is held off in the cycle that writes its constant
// - match B constant is compared with the counter, equality sets match B flag
// - match B compare is held off in the cycle that writes its constant
// - match A constants reset to all ones
// - match B constants reset to all ones
// - two-bit select decides the wave output change on match A
// - separate two-bit select decides the wave output change on match B
// - both matches together give any duty cycle, including PWM
// - cascade mode makes channel zero the upper and channel one the lower byte
// - compare-match count mode steps channel one on channel zero match A
// - counter pair and each constant pair are one sixteen-bit bus word
// - match A, match B and wrap each request an interrupt independently
// - the timer can issue a start pulse toward the converter
// - clear select 00 none, 01 match A, 10 match B, 11 external rising edge
// - each request needs its enable bit; enables reset to zero
module dtm_timer (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        extClockInCh0,
   input  wire logic        extClockInCh1,
   input  wire logic        extClearInCh0,
   input  wire logic        extClearInCh1,
   output logic             waveOutCh0,
   output logic             waveOutCh1,
   output logic [1:0]       matchAIrq,
   output logic [1:0]       matchBIrq,
   output logic [1:0]       wrapIrq,
   output logic             adcStartPulse
);

   typedef struct packed {
      logic [1:0][7:0]         count;
      logic [1:0][7:0]         matchA;
      logic [1:0][7:0]         matchB;
      logic [1:0][7:0]         ctrl;
      logic [1:0][4:0]         fctl;
      logic [1:0][2:0]         flags;
      logic [1:0]              eqAPrev;
      logic [1:0]              eqBPrev;
      logic [1:0]              extClkPrev;
      logic [1:0]              extClrPrev;
      logic [1:0]              wave;
      logic [dtm_pkg::PRESC_W-1:0] presc;
      logic                    adc;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [1:0]              rresp;
      logic [31:0]             rdata;
   } dtm_state_t;

   dtm_state_t state_r;
   dtm_state_t state_nxt;

   logic [1:0] extClk;
   logic [1:0] extClr;
   logic [1:0] eqA;
   logic [1:0] eqB;
   logic [1:0] wrMatchA;
   logic [1:0] wrMatchB;
   logic [1:0] hitA;
   logic [1:0] hitB;
   logic [1:0] tick;
   logic [1:0] clr;
   logic [1:0] wrap;
   logic [1:0] clkEdge;
   logic [1:0] clrEdge;
   logic       tick8;
   logic       tick64;
   logic       tick8k;
   logic       wrTake;
   logic       rdTake;
   logic [4:0] wrAddr;

   assign extClk = {extClockInCh1, extClockInCh0};
   assign extClr = {extClearInCh1, extClearInCh0};

   // write address and data are taken together, one write at a time
   assign wrTake        = s_axi_awvalid & s_axi_wvalid & ~state_r.bvalid;
   assign s_axi_awready = wrTake;
   assign s_axi_wready  = wrTake;
   assign rdTake        = s_axi_arvalid & ~state_r.rvalid;
   assign s_axi_arready = rdTake;
   assign wrAddr        = {s_axi_awaddr[4:2], 2'b00};

   // free-running prescaler gives one-cycle enables
   assign tick8  = (state_r.presc & dtm_pkg::MASK_DIV8)  == dtm_pkg::MASK_DIV8;
   assign tick64 = (state_r.presc & dtm_pkg::MASK_DIV64) == dtm_pkg::MASK_DIV64;
   assign tick8k = (state_r.presc & dtm_pkg::MASK_DIV8K) == dtm_pkg::MASK_DIV8K;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         logic [2:0] cks;
         logic [1:0] clrSel;
         assign cks    = state_r.ctrl[ch][dtm_pkg::CTL_CKS +: 3];
         assign clrSel = state_r.ctrl[ch][dtm_pkg::CTL_CLR +: 2];
         // the lane of the paired word that holds this channel (ch0 upper)
         assign wrMatchA[ch] = wrTake && wrAddr == dtm_pkg::OFF_MATCH_A
                               && s_axi_wstrb[1-ch];
         assign wrMatchB[ch] = wrTake && wrAddr == dtm_pkg::OFF_MATCH_B
                               && s_axi_wstrb[1-ch];
         assign eqA[ch] = state_r.count[ch] == state_r.matchA[ch];
         assign eqB[ch] = state_r.count[ch] == state_r.matchB[ch];
         // a match fires once as equality begins, not while it persists
         assign hitA[ch] = eqA[ch] & ~state_r.eqAPrev[ch] & ~wrMatchA[ch];
         assign hitB[ch] = eqB[ch] & ~state_r.eqBPrev[ch] & ~wrMatchB[ch];
         assign clkEdge[ch] = extClk[ch] ^ state_r.extClkPrev[ch];
         assign clrEdge[ch] = extClr[ch] & ~state_r.extClrPrev[ch];
         always_comb begin
            unique case (cks)
               dtm_pkg::CKS_STOP:  tick[ch] = 1'b0;
               dtm_pkg::CKS_DIV8:  tick[ch] = tick8;
               dtm_pkg::CKS_DIV64: tick[ch] = tick64;
               dtm_pkg::CKS_DIV8K: tick[ch] = tick8k;
               // ch0 counts ch1 wraps, ch1 counts ch0 match A
               dtm_pkg::CKS_CASC:  tick[ch] = (ch == 0) ? wrap[1] : hitA[0];
               dtm_pkg::CKS_EXTR:  tick[ch] = clkEdge[ch] & extClk[ch];
               dtm_pkg::CKS_EXTF:  tick[ch] = clkEdge[ch] & ~extClk[ch];
               dtm_pkg::CKS_EXTB:  tick[ch] = clkEdge[ch];
            endcase
            unique case (clrSel)
               dtm_pkg::CLR_NONE: clr[ch] = 1'b0;
               dtm_pkg::CLR_A:    clr[ch] = hitA[ch];
               dtm_pkg::CLR_B:    clr[ch] = hitB[ch];
               dtm_pkg::CLR_EXT:  clr[ch] = clrEdge[ch];
            endcase
         end
         assign wrap[ch] = tick[ch] & ~clr[ch]
                           & (state_r.count[ch] == dtm_pkg::COUNT_MAX);
         // requests follow flag and enable as levels
         assign matchAIrq[ch] = state_r.flags[ch][dtm_pkg::FLG_A]
                                & state_r.ctrl[ch][dtm_pkg::CTL_IEA];
         assign matchBIrq[ch] = state_r.flags[ch][dtm_pkg::FLG_B]
                                & state_r.ctrl[ch][dtm_pkg::CTL_IEB];
         assign wrapIrq[ch]   = state_r.flags[ch][dtm_pkg::FLG_W]
                                & state_r.ctrl[ch][dtm_pkg::CTL_IEW];
      end
   endgenerate

   always_comb begin
      logic [7:0] wByte;
      logic [1:0] osA;
      logic [1:0] osB;
      logic [2:0] setF;
      logic [2:0] clrF;
      wByte = 8'h00;
      osA   = 2'h0;
      osB   = 2'h0;
      setF  = 3'h0;
      clrF  = 3'h0;
      state_nxt = state_r;
      state_nxt.presc      = state_r.presc + 1'b1;
      state_nxt.eqAPrev    = eqA;
      state_nxt.eqBPrev    = eqB;
      state_nxt.extClkPrev = extClk;
      state_nxt.extClrPrev = extClr;
      state_nxt.adc = hitA[0] & state_r.fctl[0][dtm_pkg::FCR_ADC];
      for (int c = 0; c < 2; c++) begin
         wByte = s_axi_wdata[8*(1-c) +: 8];
         // counter: bus write, then clear, then count
         if (wrTake && wrAddr == dtm_pkg::OFF_COUNT && s_axi_wstrb[1-c]) begin
            state_nxt.count[c] = wByte;
         end else if (clr[c]) begin
            state_nxt.count[c] = dtm_pkg::COUNT_RST;
         end else if (tick[c]) begin
            state_nxt.count[c] = state_r.count[c] + 8'h01;
         end
         if (wrMatchA[c]) begin
            state_nxt.matchA[c] = wByte;
         end
         if (wrMatchB[c]) begin
            state_nxt.matchB[c] = wByte;
         end
         if (wrTake && wrAddr == (c == 0 ? dtm_pkg::OFF_CTRL0 : dtm_pkg::OFF_CTRL1)
             && s_axi_wstrb[0]) begin
            state_nxt.ctrl[c] = s_axi_wdata[7:0];
         end
         // flags are write-one-to-clear; a new event in the same cycle wins
         clrF = 3'h0;
         if (wrTake && wrAddr == (c == 0 ? dtm_pkg::OFF_FLAG0 : dtm_pkg::OFF_FLAG1)
             && s_axi_wstrb[0]) begin
            state_nxt.fctl[c] = s_axi_wdata[4:0];
            clrF = s_axi_wdata[dtm_pkg::FCR_FLG +: 3];
         end
         setF = {hitB[c], hitA[c], wrap[c]};
         state_nxt.flags[c] = (state_r.flags[c] & ~clrF) | setF;
         // wave output: match B applied first, match A takes precedence
         osA = state_r.fctl[c][dtm_pkg::FCR_OSA +: 2];
         osB = state_r.fctl[c][dtm_pkg::FCR_OSB +: 2];
         if (hitB[c]) begin
            unique case (osB)
               dtm_pkg::OS_KEEP: state_nxt.wave[c] = state_r.wave[c];
               dtm_pkg::OS_LOW:  state_nxt.wave[c] = 1'b0;
               dtm_pkg::OS_HIGH: state_nxt.wave[c] = 1'b1;
               dtm_pkg::OS_TOG:  state_nxt.wave[c] = ~state_r.wave[c];
            endcase
         end
         if (hitA[c]) begin
            unique case (osA)
               dtm_pkg::OS_KEEP: state_nxt.wave[c] = state_nxt.wave[c];
               dtm_pkg::OS_LOW:  state_nxt.wave[c] = 1'b0;
               dtm_pkg::OS_HIGH: state_nxt.wave[c] = 1'b1;
               dtm_pkg::OS_TOG:  state_nxt.wave[c] = ~state_nxt.wave[c];
            endcase
         end
      end
      // write response
      if (wrTake) begin
         state_nxt.bvalid = 1'b1;
         state_nxt.bresp  = (wrAddr <= dtm_pkg::OFF_FLAG1) ? dtm_pkg::RESP_OKAY
                                                          : dtm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         state_nxt.bvalid = 1'b0;
      end
      // read response
      if (rdTake) begin
         state_nxt.rvalid = 1'b1;
         state_nxt.rresp  = dtm_pkg::RESP_OKAY;
         unique case ({s_axi_araddr[4:2], 2'b00})
            dtm_pkg::OFF_COUNT:   state_nxt.rdata = {16'h0000, state_r.count[0],
                                                     state_r.count[1]};
            dtm_pkg::OFF_MATCH_A: state_nxt.rdata = {16'h0000, state_r.matchA[0],
                                                     state_r.matchA[1]};
            dtm_pkg::OFF_MATCH_B: state_nxt.rdata = {16'h0000, state_r.matchB[0],
                                                     state_r.matchB[1]};
            dtm_pkg::OFF_CTRL0:   state_nxt.rdata = {24'h000000, state_r.ctrl[0]};
            dtm_pkg::OFF_CTRL1:   state_nxt.rdata = {24'h000000, state_r.ctrl[1]};
            dtm_pkg::OFF_FLAG0:   state_nxt.rdata = {24'h000000, state_r.flags[0],
                                                     state_r.fctl[0]};
            dtm_pkg::OFF_FLAG1:   state_nxt.rdata = {24'h000000, state_r.flags[1],
                                                     state_r.fctl[1]};
            default: begin
               state_nxt.rdata = 32'h00000000;
               state_nxt.rresp = dtm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         state_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r.count      <= {2{dtm_pkg::COUNT_RST}};
         state_r.matchA     <= {2{dtm_pkg::MATCH_RST}};
         state_r.matchB     <= {2{dtm_pkg::MATCH_RST}};
         state_r.ctrl       <= {2{dtm_pkg::CTRL_RST}};
         state_r.fctl       <= {2{dtm_pkg::FCTL_RST}};
         state_r.flags      <= '0;
         state_r.eqAPrev    <= 2'b11;
         state_r.eqBPrev    <= 2'b11;
         state_r.extClkPrev <= 2'b00;
         state_r.extClrPrev <= 2'b00;
         state_r.wave       <= 2'b00;
         state_r.presc      <= '0;
         state_r.adc        <= 1'b0;
         state_r.bvalid     <= 1'b0;
         state_r.bresp      <= dtm_pkg::RESP_OKAY;
         state_r.rvalid     <= 1'b0;
         state_r.rresp      <= dtm_pkg::RESP_OKAY;
         state_r.rdata      <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign waveOutCh0    = state_r.wave[0];
   assign waveOutCh1    = state_r.wave[1];
   assign adcStartPulse = state_r.adc;
   assign s_axi_bvalid  = state_r.bvalid;
   assign s_axi_bresp   = state_r.bresp;
   assign s_axi_rvalid  = state_r.rvalid;
   assign s_axi_rresp   = state_r.rresp;
   assign s_axi_rdata   = state_r.rdata;

endmodule : dtm_timer

`default_nettype wire

// file: dtm_timer_assertions.sv
// port-level property checker for the two-channel timer
`timescale 1ns/1ns
`default_nettype none
module dtm_timer_assertions (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [4:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  matchAIrq,
   input wire logic [1:0]  wrapIrq,
   input wire logic        adcStartPulse
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic wrTaken;
   assign wrTaken = s_axi_awvalid && s_axi_awready;
   wr_answer_a: assert property (wrTaken |=> s_axi_bvalid)
      else $error("write taken without response");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   aw_pair_a: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wready)
      else $error("address accepted without data");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read taken without response");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] == 3'h7
      |=> s_axi_rresp == dtm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   match_irq_hold_a: assert property (!wrTaken |=> (matchAIrq & $past(matchAIrq)) == $past(matchAIrq))
      else $error("match request fell without a write");
   wrap_irq_hold_a: assert property (!wrTaken |=> (wrapIrq & $past(wrapIrq)) == $past(wrapIrq))
      else $error("wrap request fell without a write");
   adc_single_a: assert property (adcStartPulse |=> !adcStartPulse)
      else $error("converter start longer than one cycle");
   cover property (wrTaken);
   cover property (s_axi_arvalid && s_axi_arready);
   cover property ($rose(matchAIrq[1]));
   cover property (adcStartPulse);
endmodule : dtm_timer_assertions
bind dtm_timer dtm_timer_assertions chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .matchAIrq(matchAIrq),
   .wrapIrq(wrapIrq), .adcStartPulse(adcStartPulse));
`default_nettype wire

// file: dtm_ext_src.sv
// external count and clear pulse source for the timer pins
`timescale 1ns/1ns
`default_nettype none
module dtm_ext_src (
   input  wire logic       ref_clk,
   input  wire logic [3:0] pulseGo,
   input  wire logic       slow,
   output logic      [3:0] extLine
);
   int holdCnt [4] = '{default: 0};
   // a request makes a one-cycle or three-cycle high pulse; lines rest low
   always @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (pulseGo[i]) begin
            holdCnt[i] <= slow ? 3 : 1;
         end else if (holdCnt[i] != 0) begin
            holdCnt[i] <= holdCnt[i] - 1;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         extLine[i] = holdCnt[i] != 0;
      end
   end
endmodule : dtm_ext_src
`default_nettype wire

// file: dtm_tb.sv
// self-checking bench for the two-channel timer
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [4:0]  awAddr = 5'h00, arAddr = 5'h00;
   logic [31:0] wData = 32'h0;
   logic [3:0]  wStrb = 4'h0, pulseGo = 4'h0, extLine;
   logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic        awReady, wReady, bValid, arReady, rValid, wave0, wave1, adcPulse, slow = 1'b0;
   logic [1:0]  bResp, rResp, irqA, irqB, irqW;
   logic [31:0] rData, mdl [8];
   logic [15:0] rnd = 16'h0043;
   int          errorCnt = 0, comparisons = 0, cyc = 0, t0 = 0, adcCnt = 0;
   dtm_timer uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .extClockInCh0(extLine[0]), .extClockInCh1(extLine[1]),
      .extClearInCh0(extLine[2]), .extClearInCh1(extLine[3]), .waveOutCh0(wave0),
      .waveOutCh1(wave1), .matchAIrq(irqA), .matchBIrq(irqB), .wrapIrq(irqW),
      .adcStartPulse(adcPulse));
   dtm_ext_src src (.ref_clk(ref_clk), .pulseGo(pulseGo), .slow(slow), .extLine(extLine));
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      adcCnt <= adcCnt + int'(adcPulse === 1'b1);
      if (cyc == 4000) begin
         errorCnt++;
         finish_test();
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   task automatic finish_test;
      if (errorCnt == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errorCnt++;
         $display("wrong value at %0t: word %h expected %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_bit(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         errorCnt++;
         $display("wrong value at %0t: bit %b expected %b", $time, g, e);
      end
   endtask : chk_bit
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      logic tk;
      {awAddr, wData, wStrb, awValid, wValid} <= {a, d, s, 2'b11};
      do begin
         @(negedge ref_clk) tk = awReady;
         @(posedge ref_clk);
      end while (!tk);
      {awValid, wValid} <= 2'b00;
      // response left waiting one cycle so its hold is exercised
      @(posedge ref_clk);
      bReady <= 1'b1;
      do begin
         @(negedge ref_clk) {tk, r} = {bValid, bResp};
         @(posedge ref_clk);
      end while (!tk);
      bReady <= 1'b0;
      // byte lanes of the pair registers, low byte only elsewhere
      for (int l = 0; l < 2; l++)
         if (r == dtm_pkg::RESP_OKAY && a[4:2] < 3'h7 && s[l] && (l == 0 || a[4:2] < 3'h3))
            mdl[a[4:2]][8*l +: 8] = d[8*l +: 8];
      @(posedge ref_clk);
   endtask : wr
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
      logic tk;
      logic [31:0] d;
      logic [1:0]  r;
      {arAddr, arValid} <= {a, 1'b1};
      do begin
         @(negedge ref_clk) tk = arReady;
         @(posedge ref_clk);
      end while (!tk);
      arValid <= 1'b0;
      @(posedge ref_clk);
      rReady <= 1'b1;
      do begin
         @(negedge ref_clk) {tk, d, r} = {rValid, rData, rResp};
         @(posedge ref_clk);
      end while (!tk);
      rReady <= 1'b0;
      @(posedge ref_clk);
      chk_word(d, e);
      chk_word({30'h0, r}, {30'h0, er});
   endtask : rd_chk
   task automatic pulse(input int i, input logic sl);
      slow <= sl;
      pulseGo[i] <= 1'b1;
      @(posedge ref_clk);
      pulseGo <= 4'h0;
      repeat (6) @(posedge ref_clk);
   endtask : pulse
   initial begin
      logic [1:0] r;
      for (int i = 0; i < 8; i++) mdl[i] = (i == 1 || i == 2) ? 32'hffff : 32'h0;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
         rd_chk(5'(i * 4), mdl[i], i == 7 ? dtm_pkg::RESP_SLVERR : dtm_pkg::RESP_OKAY);
      wr(5'h1c, 32'hff, 4'hf, r);
      chk_word({30'h0, r}, {30'h0, dtm_pkg::RESP_SLVERR});
      for (int k = 0; k < 9; k++) begin
         rnd = lfsr(rnd);
         wr(5'(4 * (k % 3)), {rnd, rnd}, 4'(1 + k / 3), r);
         rd_chk(5'(4 * (k % 3)), mdl[k % 3], dtm_pkg::RESP_OKAY);
      end
      // channel one on clock/8, cleared and toggled by match A at 03
      wr(dtm_pkg::OFF_MATCH_A, 32'hff03, 4'h3, r);
      wr(dtm_pkg::OFF_MATCH_B, 32'hffff, 4'h3, r);
      wr(dtm_pkg::OFF_COUNT, 32'h0, 4'h3, r);
      wr(dtm_pkg::OFF_FLAG1, 32'h03, 4'h1, r);
      wr(dtm_pkg::OFF_CTRL1, 32'h49, 4'h1, r);
      for (int n = 0; n < 2; n++) begin
         do @(negedge ref_clk); while (irqA[1] !== 1'b1);
         if (n == 1) chk_word(32'(cyc - t0), 32'(dtm_pkg::DIV8 * 3));
         t0 = cyc;
         chk_bit(wave1, n == 0);
         @(posedge ref_clk);
         wr(dtm_pkg::OFF_FLAG1, 32'h43, 4'h1, r);
         @(negedge ref_clk);
         chk_bit(irqA[1], 1'b0);
         @(posedge ref_clk);
      end
      // cascade: channel one wraps on an outside edge and steps channel zero
      wr(dtm_pkg::OFF_CTRL1, 32'h25, 4'h1, r);
      wr(dtm_pkg::OFF_COUNT, 32'h12ff, 4'h3, r);
      wr(dtm_pkg::OFF_CTRL0, 32'h04, 4'h1, r);
      pulse(1, 1'b1);
      rd_chk(dtm_pkg::OFF_COUNT, 32'h1300, dtm_pkg::RESP_OKAY);
      chk_bit(irqW[1], 1'b1);
      wr(dtm_pkg::OFF_CTRL1, 32'h05, 4'h1, r);
      @(negedge ref_clk);
      chk_bit(irqW[1], 1'b0);
      @(posedge ref_clk);
      for (int c = 0; c < 4; c += 3) begin
         wr(dtm_pkg::OFF_CTRL0, 32'(c << 3), 4'h1, r);
         pulse(2, c == 0);
         rd_chk(dtm_pkg::OFF_COUNT, c == 0 ? 32'h1300 : 32'h0, dtm_pkg::RESP_OKAY);
      end
      // channel zero match A starts the converter and steps channel one
      wr(dtm_pkg::OFF_MATCH_A, 32'h0100, 4'h2, r);
      wr(dtm_pkg::OFF_FLAG0, 32'h10, 4'h1, r);
      wr(dtm_pkg::OFF_CTRL1, 32'h04, 4'h1, r);
      wr(dtm_pkg::OFF_CTRL0, 32'h05, 4'h1, r);
      pulse(0, 1'b0);
      chk_word(32'(adcCnt), 32'h1);
      chk_bit(irqA[0], 1'b0);
      rd_chk(dtm_pkg::OFF_FLAG0, 32'h50, dtm_pkg::RESP_OKAY);
      rd_chk(dtm_pkg::OFF_COUNT, 32'h0101, dtm_pkg::RESP_OKAY);
      // channel zero pwm: low on match A at 02, high and cleared on match B at 05
      wr(dtm_pkg::OFF_MATCH_A, 32'h0200, 4'h2, r);
      wr(dtm_pkg::OFF_MATCH_B, 32'h0500, 4'h2, r);
      wr(dtm_pkg::OFF_FLAG0, 32'he9, 4'h1, r);
      wr(dtm_pkg::OFF_CTRL0, 32'h91, 4'h1, r);
      do @(negedge ref_clk); while (irqB[0] !== 1'b1);
      chk_bit(wave0, 1'b1);
      t0 = cyc;
      do @(negedge ref_clk); while (wave0 !== 1'b0);
      chk_word(32'(cyc - t0), 32'(dtm_pkg::DIV8 * 2));
      chk_bit(irqB[0], 1'b1);
      finish_test();
   end
endmodule : tb
`default_nettype wire
